/* File: common/sq_timer_defs.svh */
// constants for the eight-bit square-wave timer
`ifndef SQ_TIMER_DEFS_SVH
`define SQ_TIMER_DEFS_SVH
// mode control field positions
`define MODE_OE_BIT 0
`define MODE_LVL_SET_BIT 3
`define MODE_LVL_RST_BIT 2
`define MODE_CLEAR_BIT 1
`define MODE_RUN_BIT 7
// reset values
`define COUNT_RST 8'h00
`define MODE_RST 8'h00
`endif

/* File: common/sq_timer_pkg.sv */
// types for the eight-bit square-wave timer
package sq_timer_pkg;
  typedef logic [7:0] byte_t;
endpackage

/* File: core/sq_timer.sv */
// eight-bit interval timer with square-wave output
// Overview of operation
// R1: with output enabled, each match inverts the output, giving 50% duty.
// R2: level-set 0 with level-reset 1 clears output; swapped pattern sets it.
// R3: software writes one of two mode patterns enabling output and clear.
// R4: counter stays stopped until the count-run bit is set to one.
// R5: on match, invert output, pulse match interrupt, clear counter to zero.
// R6: output frequency is one over twice tick period times compare plus one.
// R7: software must not change compare value while counting.
// R8: software clears port latch and direction bits before starting.
// R9: software picks count clock and compare value before enabling counting.
// R10: counter increments per selected tick and holds while run bit is clear.
`include "sq_timer_defs.svh"
module sq_timer
  import sq_timer_pkg::*;
#(
  parameter int DIV_W = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] timer_mode_ctrl_i,
  input wire logic mode_wr_i,
  input wire logic [DIV_W-1:0] count_clock_select_i,
  input wire logic [7:0] compare_value_reg_i,
  output logic square_out_pin_o,
  output logic match_interrupt_o,
  output logic [7:0] up_counter_o
);
  logic rst_s1_q, rst_n_q;
  logic [(1<<DIV_W)-1:0] pre_q;
  logic [(1<<DIV_W)-1:0] pre_d;
  logic tick_q;
  byte_t cnt_q, cnt_d;
  logic ff_q, ff_d;
  logic irq_d;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // decoding of mode bits
  // R3 output enable and clear-on-match pick square-wave mode
  wire run = timer_mode_ctrl_i[`MODE_RUN_BIT];
  wire oe = timer_mode_ctrl_i[`MODE_OE_BIT];
  wire clr_mode = timer_mode_ctrl_i[`MODE_CLEAR_BIT];
  wire lvs = timer_mode_ctrl_i[`MODE_LVL_SET_BIT];
  wire lvr = timer_mode_ctrl_i[`MODE_LVL_RST_BIT];
  // ticks come when the low select bits of the prescaler are all ones;
  // select 0 ticks every clock, select k every 2**k clocks
  function automatic logic tick_due(input logic [(1<<DIV_W)-1:0] pre,
                                    input logic [DIV_W-1:0] sel);
    logic [(1<<DIV_W)-1:0] mask;
    mask = '0;
    for (int i = 0; i < (1 << DIV_W); i++) begin
      if (i < int'(sel)) mask[i] = 1'b1;
    end
    return (pre & mask) == mask;
  endfunction

  // clocks in one half period: compare plus one, times the tick divisor
  function automatic logic [15:0] half_cycles(input logic [7:0] n,
                                              input logic [DIV_W-1:0] sel);
    return ({8'h00, n} + 16'h0001) << sel;
  endfunction

  wire sel_tick = tick_due(pre_q, count_clock_select_i);
  assign pre_d = pre_q + 1'b1;
  wire match = run && tick_q && (cnt_q == compare_value_reg_i);

  // R10 count on tick, hold when stopped
  // R5 clear counter on match in clear mode
  always_comb begin
    cnt_d = cnt_q;
    if (!run) cnt_d = cnt_q;
    else if (match && clr_mode) cnt_d = `COUNT_RST;
    else if (tick_q) cnt_d = cnt_q + 8'h01;
  end

  // R2 level preset on mode write, R1 toggle on match
  always_comb begin
    ff_d = ff_q;
    if (mode_wr_i && lvs && !lvr) ff_d = 1'b1;
    else if (mode_wr_i && !lvs && lvr) ff_d = 1'b0;
    else if (match && oe) ff_d = ~ff_q;
  end
  assign irq_d = match;

  // prescaler and count clock tick
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pre_q <= '0;
      tick_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      tick_q <= sel_tick;
    end
  end

  // R4 counter, output flop and interrupt
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_q <= `COUNT_RST;
      ff_q <= 1'b0;
      square_out_pin_o <= 1'b0;
      match_interrupt_o <= 1'b0;
      up_counter_o <= `COUNT_RST;
    end else begin
      cnt_q <= cnt_d;
      ff_q <= ff_d;
      square_out_pin_o <= ff_d & oe;
      match_interrupt_o <= irq_d;
      up_counter_o <= cnt_d;
    end
  end

  // checks below watch the counter, the output flop, the pin and the interrupt;
  // compare and select are held by software while counting, so the
  // period check only arms after the first toggle of each run, whose
  // spacing depends on the free-running prescaler phase

  // R6 helper: clocks between output toggles while running
  logic [15:0] gap_q;
  logic gap_ok_q;
  wire [15:0] half_len = half_cycles(compare_value_reg_i,
                                     count_clock_select_i);
  // restart the measure on stop or mode write; first toggle only arms it
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gap_q <= 16'h0000;
      gap_ok_q <= 1'b0;
    end else if (!run || mode_wr_i) begin
      gap_q <= 16'h0000;
      gap_ok_q <= 1'b0;
    end else if (match && oe) begin
      gap_q <= 16'h0001;
      gap_ok_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 16'h0001; // wraps harmlessly, read only on toggle
    end
  end

  // R4 counter frozen while stopped
  a_stop_holds: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    !run && !$past(run) |-> cnt_q == $past(cnt_q)) // R4
    else $error("counter moved while stopped");

  // R5 match clears counter
  a_match_clears: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    match && clr_mode |=> cnt_q == 8'h00) // R5
    else $error("counter not cleared after match");

  // R5 interrupt follows match
  a_irq_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    match |=> match_interrupt_o) // R5
    else $error("no interrupt after match");

  // R1 toggle on match
  a_toggle_match: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    match && oe && !mode_wr_i |=> ff_q != $past(ff_q)) // R1
    else $error("output not inverted on match");

  // R2 level set
  a_level_set: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    mode_wr_i && lvs && !lvr |=> ff_q) // R2
    else $error("level set failed");

  // R2 level clear
  a_level_clr: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    mode_wr_i && !lvs && lvr |=> !ff_q) // R2
    else $error("level clear failed");

  // R10 increment by one on tick
  a_count_step: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    run && tick_q && !match |=> cnt_q == $past(cnt_q) + 8'h01) // R10
    else $error("counter did not step by one");

  // R6 no count beyond compare in clear mode
  a_period_bound: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    run && clr_mode && cnt_q == compare_value_reg_i && tick_q
    |=> cnt_q == 8'h00) // R6
    else $error("period exceeds compare plus one");

  // R6 half period is compare plus one ticks
  a_half_period: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    gap_ok_q && match && oe |-> gap_q == half_len) // R6
    else $error("half period length wrong");

  // R6 counter never passes the compare value while running in clear mode
  a_no_overrun: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    run && clr_mode && cnt_q <= compare_value_reg_i
    |=> cnt_q <= $past(compare_value_reg_i)) // R6
    else $error("counter passed compare value");

  // R5 interrupt only right after a match
  a_irq_single: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    !match |=> !match_interrupt_o) // R5
    else $error("interrupt without match");

  // R1 pin shows output flop gated by enable
  a_pin_follows: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    1'b1 |=> square_out_pin_o == (ff_q & $past(oe))) // R1
    else $error("pin differs from output flop");

  // R2 output flop holds between events
  a_hold_level: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    !mode_wr_i && !(match && oe) |=> ff_q == $past(ff_q)) // R2
    else $error("output flop changed without event");

  // R10 counter port mirrors the counter
  a_count_mirror: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    1'b1 |=> up_counter_o == cnt_q) // R10
    else $error("counter port differs from counter");
endmodule

/* File: test/sq_rx.sv */
// receiver model timing the square-wave half periods
module sq_rx (
  input wire logic clk_i,
  input wire logic pin_i,
  output int half_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  logic last_q = 1'b0;
  // pin taken as routed: port latch and direction bits cleared
  // cycles between two pin edges
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    last_q <= pin_i;
    if (pin_i !== last_q) begin
      half_o <= cnt;
      cnt <= 1;
    end
  end
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the square-wave timer
module tb_top;
  import sq_timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_n_i = 0, wr = 0, pin, irq;
  byte_t mode = 8'h00, cmp = 8'h00, cnt;
  logic [2:0] sel = 3'h0;
  int half, err_count = 0, comparisons = 0;
  sq_timer dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .timer_mode_ctrl_i(mode),
    .mode_wr_i(wr), .count_clock_select_i(sel),
    .compare_value_reg_i(cmp), .square_out_pin_o(pin),
    .match_interrupt_o(irq), .up_counter_o(cnt));
  sq_rx rx (.clk_i(clk_i), .pin_i(pin), .half_o(half));
  initial forever #4 clk_i = ~clk_i;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // mode, tick and compare loaded while stopped
  task setup(input byte_t m, input logic [2:0] s, input byte_t n);
    @(negedge clk_i);
    {mode, sel, cmp, wr} = {m, s, n, 1'b1};
    @(negedge clk_i);
    wr = 0;
    repeat (2) @(negedge clk_i);
  endtask
  task run(input byte_t m, input logic [2:0] s, input byte_t n);
    byte_t held;
    int waited;
    // fresh reset so every scenario starts from a cleared counter
    @(negedge clk_i);
    rst_n_i = 0;
    mode = 8'h00;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1;
    repeat (3) @(negedge clk_i);
    setup(m, s, n);
    chk(pin, m[3]);
    repeat (9) @(negedge clk_i);
    chk(cnt, 8'h00);
    mode[7] = 1'b1;
    repeat (3 * ((n + 1) << s) + 9) @(negedge clk_i);
    chk(half, (n + 1) << s);
    waited = 0;
    while (irq !== 1'b1 && waited < 4096) begin
      @(negedge clk_i);
      waited++;
    end
    chk(irq, 1'b1);
    chk(cnt, 8'h00);
    @(negedge clk_i);
    chk(irq, 1'b0);
    mode[7] = 1'b0;
    @(negedge clk_i);
    held = cnt;
    repeat (5) @(negedge clk_i);
    chk(cnt, held);
    $display("test n=%h sel=%0d done", n, s);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    end_sim;
  end
  initial begin
    repeat (6) @(negedge clk_i);
    rst_n_i = 1;
    repeat (3) @(negedge clk_i);
    run(8'h0B, 3'h0, 8'h01);
    run(8'h07, 3'h1, 8'h00);
    run(8'h0B, 3'h0, 8'hFF);
    run(8'h07, 3'h2, 8'h04);
    end_sim;
  end
endmodule
